// *** shared/sarpr_pkg.sv ***
// constants for the sar converter conversion control and parallel readout
// assumes a single 125 MHz clock (mclk) for all digital logic
package sarpr_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned DATA_W = 16;
  // conversion time, longest allowed
  localparam int unsigned CONV_TIME_NS = 400;
  localparam int unsigned CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 6;
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
  localparam logic [DATA_W-1:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0] FILL_ONES = 8'hff;
  typedef enum logic [1:0] {SARPR_SAMPLE, SARPR_CONVERT, SARPR_DRAIN} sarpr_state_t;
endpackage

// *** hw/sarpr_adc.sv ***
// conversion control and parallel readout of a 16-bit sar converter
// assumes host pins arrive asynchronous to mclk; comparator bit arrives on mclk
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - reset low aborts conversion, clears result latch
// - reset acts regardless of chip select
// - select and read low drive latest result
// - conversion timed by internal clock only
// - conversion completes within 400 ns
// - input sampled and held at conversion start
// - busy high from start until the result enters the two-entry buffer
// - data bus tristate unless select and read low
// - byte select folds low byte, ones below
module sarpr_adc
  import sarpr_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // host pins, active low except byte_select
  input wire logic reset_n,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic convert_start_n,
  input wire logic byte_select,
  // analog front end
  output logic sample_hold,
  output logic [DATA_W-1:0] dac_trial,
  input wire logic comparator_high,
  // parallel result bus
  output logic [DATA_W-1:0] parallel_result_bus_out,
  output logic parallel_result_bus_oe,
  output logic busy
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] rst_sync_reg, rst_sync_next;
  logic [2:0] cs_sync_reg, cs_sync_next;
  logic [2:0] rd_sync_reg, rd_sync_next;
  logic [2:0] cv_sync_reg, cv_sync_next;
  logic [2:0] by_sync_reg, by_sync_next;
  logic rst_n_reg, rst_n_next;
  logic cs_n_reg, cs_n_next;
  logic rd_n_reg, rd_n_next;
  logic cv_n_reg, cv_n_next;
  logic by_reg, by_next;

  // change accepted only when stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  always_comb
  begin
    rst_sync_next = {rst_sync_reg[1:0], reset_n};
    cs_sync_next = {cs_sync_reg[1:0], chip_select_n};
    rd_sync_next = {rd_sync_reg[1:0], read_n};
    cv_sync_next = {cv_sync_reg[1:0], convert_start_n};
    by_sync_next = {by_sync_reg[1:0], byte_select};
    rst_n_next = filt(rst_sync_reg, rst_n_reg);
    cs_n_next = filt(cs_sync_reg, cs_n_reg);
    rd_n_next = filt(rd_sync_reg, rd_n_reg);
    cv_n_next = filt(cv_sync_reg, cv_n_reg);
    by_next = filt(by_sync_reg, by_reg);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rst_sync_reg <= 3'h7;
      cs_sync_reg <= 3'h7;
      rd_sync_reg <= 3'h7;
      cv_sync_reg <= 3'h7;
      by_sync_reg <= 3'h0;
      rst_n_reg <= 1'b1;
      cs_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      cv_n_reg <= 1'b1;
      by_reg <= 1'b0;
    end
    else
    begin
      rst_sync_reg <= rst_sync_next;
      cs_sync_reg <= cs_sync_next;
      rd_sync_reg <= rd_sync_next;
      cv_sync_reg <= cv_sync_next;
      by_sync_reg <= by_sync_next;
      rst_n_reg <= rst_n_next;
      cs_n_reg <= cs_n_next;
      rd_n_reg <= rd_n_next;
      cv_n_reg <= cv_n_next;
      by_reg <= by_next;
    end
  end

  logic cv_fall;
  logic abort;
  assign abort = reset || !rst_n_reg;
  assign cv_fall = cv_n_reg && !cv_n_next && !cs_n_reg;

  // ****************************************
  // conversion sequencer
  // ****************************************
  sarpr_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [DATA_W-1:0] sar_reg, sar_next;
  logic [DATA_W-1:0] bit_reg, bit_next;
  logic [4:0] step_reg, step_next;
  logic done;
  // two-entry buffer between sequencer and output latch
  logic [DATA_W-1:0] buf_data_reg [2];
  logic [DATA_W-1:0] buf_data_next [2];
  logic [1:0] buf_cnt_reg, buf_cnt_next;
  logic buf_in_ready, buf_out_valid, buf_out_ready;
  logic [DATA_W-1:0] result_reg, result_next;
  logic reading;

  assign buf_in_ready = (buf_cnt_reg != 2'h2);
  assign buf_out_valid = (buf_cnt_reg != 2'h0);
  // latch may not change under an active read
  assign buf_out_ready = !reading;
  assign done = (state_reg == SARPR_CONVERT) && (cnt_reg == CONV_LAST);

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sar_next = sar_reg;
    bit_next = bit_reg;
    step_next = step_reg;
    case (state_reg)
      SARPR_SAMPLE:
        if (cv_fall && buf_in_ready)
        begin
          state_next = SARPR_CONVERT;
          cnt_next = CNT_RESET;
          sar_next = {1'b1, 15'h0000};
          bit_next = {1'b1, 15'h0000};
          step_next = 5'h00;
        end
      SARPR_CONVERT:
      begin
        // one trial per mclk step, internal clock only
        cnt_next = cnt_reg + 6'h01;
        if (step_reg < 5'h10)
        begin
          // sar trial: keep bit if input above trial
          if (!comparator_high)
            sar_next = sar_reg & ~bit_reg;
          if (bit_reg > 16'h0001)
            sar_next = (comparator_high ? sar_reg : sar_reg & ~bit_reg) | (bit_reg >> 1);
          bit_next = bit_reg >> 1;
          step_next = step_reg + 5'h01;
        end
        if (done)
          state_next = buf_in_ready ? SARPR_SAMPLE : SARPR_DRAIN;
      end
      SARPR_DRAIN:
        if (buf_in_ready)
          state_next = SARPR_SAMPLE;
      default:
        state_next = SARPR_SAMPLE;
    endcase
    // clearing the datapath too keeps dac_trial defined after reset
    if (abort)
    begin
      state_next = SARPR_SAMPLE;
      cnt_next = CNT_RESET;
      sar_next = RESULT_RESET;
      bit_next = RESULT_RESET;
      step_next = 5'h00;
    end
  end

  always_comb
  begin
    buf_data_next = buf_data_reg;
    buf_cnt_next = buf_cnt_reg;
    result_next = result_reg;
    if (buf_out_valid && buf_out_ready)
    begin
      result_next = buf_data_reg[0];
      buf_data_next[0] = buf_data_reg[1];
      buf_cnt_next = buf_cnt_reg - 2'h1;
    end
    if ((done || state_reg == SARPR_DRAIN) && buf_in_ready)
    begin
      buf_data_next[buf_cnt_next[0]] = sar_reg;
      buf_cnt_next = buf_cnt_next + 2'h1;
    end
    if (abort)
    begin
      buf_cnt_next = 2'h0;
      result_next = RESULT_RESET;
    end
  end

  always_ff @(posedge mclk)
  begin
    state_reg <= state_next;
    cnt_reg <= cnt_next;
    sar_reg <= sar_next;
    bit_reg <= bit_next;
    step_reg <= step_next;
    buf_data_reg <= buf_data_next;
    buf_cnt_reg <= buf_cnt_next;
    result_reg <= result_next;
  end

  // ****************************************
  // outputs
  // ****************************************
  logic [DATA_W-1:0] bus_reg, bus_next;
  logic oe_reg, oe_next;
  assign reading = !cs_n_reg && !rd_n_reg;

  always_comb
  begin
    oe_next = reading && !abort;
    bus_next = by_reg ? {result_reg[7:0], FILL_ONES} : result_reg;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      bus_reg <= RESULT_RESET;
      oe_reg <= 1'b0;
    end
    else
    begin
      bus_reg <= bus_next;
      oe_reg <= oe_next;
    end
  end

  assign parallel_result_bus_out = bus_reg;
  assign parallel_result_bus_oe = oe_reg;
  assign busy = (state_reg != SARPR_SAMPLE);
  assign sample_hold = busy;
  assign dac_trial = sar_reg;

  // ****************************************
  // checks
  // ****************************************
  sequence s_start;
    state_reg == SARPR_SAMPLE && cv_fall && buf_in_ready && !abort;
  endsequence
  property p_busy_start;
    @(posedge mclk) disable iff (reset) s_start |=> busy && sample_hold;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not raised");
  property p_conv_len;
    @(posedge mclk) disable iff (reset) s_start |-> ##51 (!busy || state_reg == SARPR_DRAIN);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion too long");
  property p_abort;
    @(posedge mclk) disable iff (reset) !rst_n_reg |=> !busy && result_reg == 16'h0000;
  endproperty
  a_abort: assert property (p_abort) else $error("reset did not clear");
  property p_tristate;
    @(posedge mclk) disable iff (reset) !reading |=> !parallel_result_bus_oe;
  endproperty
  a_tristate: assert property (p_tristate) else $error("bus driven when idle");
  property p_drive;
    @(posedge mclk) disable iff (reset) reading && rst_n_reg |=> parallel_result_bus_oe;
  endproperty
  a_drive: assert property (p_drive) else $error("bus not driven");
  property p_fold;
    @(posedge mclk) disable iff (reset)
      by_reg |=> parallel_result_bus_out[7:0] == 8'hff
        && parallel_result_bus_out[15:8] == $past(result_reg[7:0]);
  endproperty
  a_fold: assert property (p_fold) else $error("byte fold wrong");
  property p_hold;
    @(posedge mclk) disable iff (reset) reading && rst_n_reg |=> $stable(result_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed");
  property p_ind;
    @(posedge mclk) disable iff (reset) !rst_n_reg && cs_n_reg |=> !busy;
  endproperty
  a_ind: assert property (p_ind) else $error("reset ignored deselected");
endmodule
`default_nettype wire

// *** verification/sarpr_front_model.sv ***
// comparator stand-in facing the converter's analog side
// assumes dac_trial is an unsigned trial word judged on every mclk edge
`timescale 1ns/1ns
`default_nettype none
module sarpr_front_model
  import sarpr_pkg::*;
(
  // clock
  input wire logic mclk,
  // analog side
  input wire logic [DATA_W-1:0] vin,
  input wire logic sample_hold,
  input wire logic [DATA_W-1:0] dac_trial,
  output logic comparator_high
);
  logic [DATA_W-1:0] held_reg = 16'h0000;
  logic junk_reg = 1'b0;
  // input frozen at the hold edge; later moves of vin must not leak in
  always_ff @(posedge mclk)
  begin
    junk_reg <= ~junk_reg;
    if (!sample_hold)
    begin
      held_reg <= vin;
    end
  end
  // outside a hold the decision is meaningless, so it toggles
  assign comparator_high = sample_hold ? (held_reg >= dac_trial) : junk_reg;
endmodule
`default_nettype wire

// *** verification/tb_sar_adc_parallel_readout.sv ***
// self-checking bench: host pins driven here, comparator from the front model
// assumes mclk at 125 MHz and about four cycles of pin latency
`timescale 1ns/1ns
`default_nettype none
module tb_sar_adc_parallel_readout
  import sarpr_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic reset_n = 1'b1;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic cv_n = 1'b1;
  logic byte_sel = 1'b0;
  logic [DATA_W-1:0] vin = 16'h0000;
  logic sample_hold, cmp_high, oe, busy;
  logic [DATA_W-1:0] trial, bus;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  sarpr_adc uut (.mclk(mclk), .reset(reset), .reset_n(reset_n), .chip_select_n(cs_n),
    .read_n(rd_n), .convert_start_n(cv_n), .byte_select(byte_sel), .sample_hold(sample_hold),
    .dac_trial(trial), .comparator_high(cmp_high), .parallel_result_bus_out(bus),
    .parallel_result_bus_oe(oe), .busy(busy));
  sarpr_front_model front (.mclk(mclk), .vin(vin), .sample_hold(sample_hold),
    .dac_trial(trial), .comparator_high(cmp_high));
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // start with select low; vin moves to late_v once busy is up
  task automatic convert(input logic [DATA_W-1:0] late_v, output int len);
    int w;
    cs_n = 1'b0;
    cyc(16);
    cv_n = 1'b0;
    for (w = 0; w < 10 && busy !== 1'b1; w++) cyc(1);
    check(16'(busy), 16'h0001);
    check(16'(sample_hold), 16'h0001);
    cv_n = 1'b1;
    vin = late_v;
    // busy fall used as the ready interrupt; len counts busy-high cycles
    for (len = 0; len < 100 && busy === 1'b1; len++) cyc(1);
    cyc(4);
  endtask
  task automatic read(input logic b, input logic [DATA_W-1:0] exp);
    byte_sel = b;
    cs_n = 1'b0;
    rd_n = 1'b0;
    cyc(6);
    check(16'(oe), 16'h0001);
    check(bus, exp);
    rd_n = 1'b1;
    cyc(6);
    check(16'(oe), 16'h0000);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_convert_and_fold();
    int len;
    vin = 16'ha5c3;
    convert(16'h1234, len);
    check(16'(len), 16'(CONV_CYCLES));
    read(1'b0, 16'ha5c3);
    read(1'b1, {8'hc3, FILL_ONES});
  endtask
  task automatic s_back_to_back();
    int len;
    vin = 16'h8001;
    convert(16'h7ffe, len);
    convert(16'h8001, len);
    check(16'(len), 16'(CONV_CYCLES));
    read(1'b0, 16'h7ffe);
    // select settles high before the start edge, so the start must be ignored
    cs_n = 1'b1;
    cyc(8);
    cv_n = 1'b0;
    cyc(8);
    cv_n = 1'b1;
    check(16'(busy), 16'h0000);
    read(1'b0, 16'h7ffe);
  endtask
  task automatic s_reset_pin();
    cs_n = 1'b1;
    reset_n = 1'b0;
    cyc(8);
    reset_n = 1'b1;
    cyc(8);
    read(1'b0, 16'h0000);
    vin = 16'h0f0f;
    cs_n = 1'b0;
    cyc(16);
    cv_n = 1'b0;
    cyc(8);
    cv_n = 1'b1;
    cs_n = 1'b1;
    reset_n = 1'b0;
    cyc(8);
    check(16'(busy), 16'h0000);
    reset_n = 1'b1;
    cyc(60);
    read(1'b0, 16'h0000);
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      finish_test();
    end
  end
  initial
  begin
    cyc(16);
    reset = 1'b0;
    cyc(6);
    check(16'(oe), 16'h0000);
    check(16'(busy), 16'h0000);
    s_convert_and_fold();
    s_back_to_back();
    s_reset_pin();
    finish_test();
  end
endmodule
`default_nettype wire
